//--- hdl/uhp_consts.svh
`ifndef UHP_CONSTS_SVH
`define UHP_CONSTS_SVH
`define UHP_NUM_PIPES 7
`define UHP_OFS_SELECT 8'h00
`define UHP_OFS_CONTROL 8'h04
`define UHP_OFS_TTEP 8'h08
`define UHP_OFS_SIZE_BANKS 8'h0C
`define UHP_OFS_POLL 8'h10
`define UHP_OFS_STATUS 8'h14
`define UHP_OFS_INRQ 8'h18
`define UHP_OFS_ERROR 8'h1C
`define UHP_OFS_PIPE_RESET 8'h20
`define UHP_OFS_PIPE_FLAGS 8'h24
`define UHP_CTL_ON 0
`define UHP_CTL_RESTART 3
`define UHP_CTL_UNBOUNDED 5
`define UHP_CTL_HALT 6
`define UHP_CTL_FLOW_EN 7
`define UHP_SB_MEMORY_ALLOCATE 1
`define UHP_SB_BANK_LSB 2
`define UHP_SB_SIZE_LSB 4
`define UHP_ST_OK 7
`define UHP_ST_OVF 6
`define UHP_ST_UNF 5
`define UHP_ST_TOG_LSB 2
`define UHP_ERR_TALLY_LSB 5
`define UHP_SEL_MASK 8'h07
`define UHP_CTL_MASK 8'hE9
`define UHP_SB_MASK 8'h7E
`define UHP_ERR_MASK 8'h7F
`define UHP_RESET_MASK 8'h7F
`define UHP_REG_RESET 8'h00
`define UHP_TALLY_LIMIT 2'h3
`define UHP_MAX_STD_SIZE 3'h3
`define UHP_MAX_EXT_SIZE 3'h5
`define UHP_EXT_SIZE_EP 4'h1
`define UHP_MAX_BANK 2'h1
`define UHP_RESP_OKAY 2'h0
`define UHP_RESP_DECERR 2'h3
`endif

//--- hdl/uhp_err_track.sv
`include "uhp_consts.svh"
`default_nettype none
module uhp_err_track (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pipe_rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic [4:0] err_set,
  output logic [4:0] err_flags_q,
  output logic [1:0] error_tally_q,
  output logic tally_full
);
  logic any_err;
  assign any_err = |err_set;
  assign tally_full = (error_tally_q == `UHP_TALLY_LIMIT);

  // Error flags clear only by a written zero or a pipe reset; a new event wins over the zero.
  always_ff @(posedge core_clk) begin
    if (rst || pipe_rst) begin
      err_flags_q <= 5'h00;
    end else if (wr_en) begin
      err_flags_q <= (err_flags_q & wdata[4:0]) | err_set;
    end else begin
      err_flags_q <= err_flags_q | err_set;
    end
  end

  // Tally saturates at its limit; software writes replace it, but a counted error in the same cycle wins over the write.
  always_ff @(posedge core_clk) begin
    if (rst || pipe_rst) begin
      error_tally_q <= 2'h0;
    end else if (any_err && !tally_full) begin
      error_tally_q <= error_tally_q + 2'h1;
    end else if (wr_en) begin
      error_tally_q <= wdata[`UHP_ERR_TALLY_LSB +: 2];
    end
  end
endmodule
`default_nettype wire

//--- hdl/uhp_memory_allocate_check.sv
`include "uhp_consts.svh"
`default_nettype none
module uhp_memory_allocate_check (
  input wire logic [2:0] pipe_capacity_sel,
  input wire logic [1:0] bank_count_sel,
  input wire logic [3:0] target_endpoint,
  output logic fits
);
  // Large sizes are only legal on endpoint 1; reserved codes never allocate.
  always_comb begin
    fits = (bank_count_sel <= `UHP_MAX_BANK) &&
           ((pipe_capacity_sel <= `UHP_MAX_STD_SIZE) ||
            ((pipe_capacity_sel <= `UHP_MAX_EXT_SIZE) && (target_endpoint == `UHP_EXT_SIZE_EP)));
  end
endmodule
`default_nettype wire

//--- hdl/uhp_pipe_ctl.sv
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`include "uhp_consts.svh"
`default_nettype none
module uhp_pipe_ctl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uhp_pkg::uhp_event_t ev,
  input wire logic [2:0] eng_pipe,
  output uhp_pkg::uhp_view_t eng_view,
  output logic [6:0] req_allowed,
  output logic [6:0] flow_err_req,
  output logic zlp_send
);
  localparam int NP = `UHP_NUM_PIPES;

  logic [2:0] pipe_select_q;
  logic [6:0] pipe_on_q;
  logic [6:0] unbounded_q;
  logic [6:0] flow_en_q;
  logic [6:0] pipe_halt_q;
  logic [6:0] restart_q;
  logic [7:0] ttep_q [NP];
  logic [7:0] size_banks_q [NP];
  logic [7:0] poll_q [NP];
  logic [6:0] memory_allocate_ok_q;
  logic [6:0] overflow_q;
  logic [6:0] underflow_q;
  logic [6:0] toggle_q;
  logic [1:0] busy_q [NP];
  logic [7:0] in_request_tally_q [NP];
  logic [6:0] pipe_reset_q;
  logic [4:0] err_flags [NP];
  logic [1:0] error_tally [NP];
  logic [6:0] tally_full;
  logic [6:0] fits;
  logic [6:0] ev_hit;
  logic [6:0] wr_hit;
  logic zlp_d;

  logic wr_fire;
  logic rd_fire;
  logic wr_lane;
  logic wr_sel;
  logic wr_ctl;
  logic wr_ttep;
  logic wr_sb;
  logic wr_poll;
  logic wr_stat;
  logic wr_inrq;
  logic wr_err;
  logic wr_prst;
  logic wr_bad;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic rd_bad;
  logic [2:0] rp;

  assign wd = s_axi_wdata[7:0];
  assign wr_lane = s_axi_wstrb[0];

  // Address and data are taken together so no partial write is ever held.
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_fire;

  always_comb begin
    wr_sel = 1'b0;
    wr_ctl = 1'b0;
    wr_ttep = 1'b0;
    wr_sb = 1'b0;
    wr_poll = 1'b0;
    wr_stat = 1'b0;
    wr_inrq = 1'b0;
    wr_err = 1'b0;
    wr_prst = 1'b0;
    wr_bad = 1'b0;
    if (s_axi_awaddr == `UHP_OFS_SELECT) begin
      wr_sel = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_CONTROL) begin
      wr_ctl = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_TTEP) begin
      wr_ttep = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_SIZE_BANKS) begin
      wr_sb = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_POLL) begin
      wr_poll = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_STATUS) begin
      wr_stat = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_INRQ) begin
      wr_inrq = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_ERROR) begin
      wr_err = 1'b1;
    end else if (s_axi_awaddr == `UHP_OFS_PIPE_RESET) begin
      wr_prst = 1'b1;
    end else if (s_axi_awaddr != `UHP_OFS_PIPE_FLAGS) begin
      wr_bad = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UHP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? `UHP_RESP_DECERR : `UHP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pipe_select_q <= 3'h0;
    end else if (wr_fire && wr_lane && wr_sel) begin
      pipe_select_q <= wd[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pipe_reset_q <= 7'h00;
    end else if (wr_fire && wr_lane && wr_prst) begin
      pipe_reset_q <= wd[6:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pipe
      assign wr_hit[g] = wr_fire && wr_lane && (pipe_select_q == 3'(g));
      assign ev_hit[g] = ev.valid && (ev.pipe == 3'(g));
      uhp_memory_allocate_check u_fit (
        .pipe_capacity_sel(size_banks_q[g][`UHP_SB_SIZE_LSB +: 3]),
        .bank_count_sel(size_banks_q[g][`UHP_SB_BANK_LSB +: 2]),
        .target_endpoint(ttep_q[g][3:0]),
        .fits(fits[g])
      );
      uhp_err_track u_err (
        .core_clk(core_clk),
        .rst(rst),
        .pipe_rst(pipe_reset_q[g]),
        .wr_en(wr_hit[g] && wr_err),
        .wdata(wd),
        .err_set(ev_hit[g] ? {ev.crc, ev.timeout, ev.pid, ev.data_pid, ev.toggle_bad} : 5'h00),
        .err_flags_q(err_flags[g]),
        .error_tally_q(error_tally[g]),
        .tally_full(tally_full[g])
      );
      assign req_allowed[g] = pipe_on_q[g] && memory_allocate_ok_q[g] && !pipe_halt_q[g];
      assign flow_err_req[g] = flow_en_q[g] && (overflow_q[g] || underflow_q[g]);
    end
  endgenerate

  // Configuration is untouched by a pipe reset, only by system reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pipe_on_q <= 7'h00;
      unbounded_q <= 7'h00;
      flow_en_q <= 7'h00;
      for (int p = 0; p < NP; p++) begin
        ttep_q[p] <= `UHP_REG_RESET;
        size_banks_q[p] <= `UHP_REG_RESET;
        poll_q[p] <= `UHP_REG_RESET;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit[p] && wr_ctl) begin
          pipe_on_q[p] <= wd[`UHP_CTL_ON];
          unbounded_q[p] <= wd[`UHP_CTL_UNBOUNDED];
          flow_en_q[p] <= wd[`UHP_CTL_FLOW_EN];
        end
        if (wr_hit[p] && wr_ttep) begin
          ttep_q[p] <= wd;
        end
        if (wr_hit[p] && wr_sb) begin
          size_banks_q[p] <= wd & `UHP_SB_MASK;
        end
        if (wr_hit[p] && wr_poll) begin
          poll_q[p] <= wd;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      memory_allocate_ok_q <= 7'h00;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (!pipe_on_q[p] || !size_banks_q[p][`UHP_SB_MEMORY_ALLOCATE]) begin
          memory_allocate_ok_q[p] <= 1'b0;
        end else begin
          memory_allocate_ok_q[p] <= fits[p];
        end
      end
    end
  end

  // Hardware halt causes are applied after the software write so they win.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pipe_halt_q <= 7'h7F;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit[p] && wr_ctl) begin
          pipe_halt_q[p] <= wd[`UHP_CTL_HALT];
        end
        if (pipe_reset_q[p] || (wr_hit[p] && wr_ctl && wd[`UHP_CTL_ON] && !pipe_on_q[p])) begin
          pipe_halt_q[p] <= 1'b1;
        end
        if (!memory_allocate_ok_q[p] || (ev_hit[p] && ev.stall) || tally_full[p]) begin
          pipe_halt_q[p] <= 1'b1;
        end
        if (ev_hit[p] && ev.in_ok && !unbounded_q[p] && (in_request_tally_q[p] == 8'h00)) begin
          pipe_halt_q[p] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int p = 0; p < NP; p++) begin
        in_request_tally_q[p] <= `UHP_REG_RESET;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit[p] && wr_inrq) begin
          in_request_tally_q[p] <= wd;
        end else if (ev_hit[p] && ev.in_ok && !unbounded_q[p] && (in_request_tally_q[p] != 8'h00)) begin
          in_request_tally_q[p] <= in_request_tally_q[p] - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      restart_q <= 7'h00;
      toggle_q <= 7'h00;
    end else begin
      for (int p = 0; p < NP; p++) begin
        restart_q[p] <= wr_hit[p] && wr_ctl && wd[`UHP_CTL_RESTART];
        if (restart_q[p] || pipe_reset_q[p]) begin
          toggle_q[p] <= 1'b0;
        end else if (ev_hit[p] && ev.in_ok) begin
          toggle_q[p] <= ev.rx_toggle;
        end else if (ev_hit[p] && ev.tx_done) begin
          toggle_q[p] <= !toggle_q[p];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int p = 0; p < NP; p++) begin
        busy_q[p] <= 2'h0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (pipe_reset_q[p]) begin
          busy_q[p] <= 2'h0;
        end else if (ev_hit[p] && ev.busy_upd && (ev.busy != 2'h3)) begin
          busy_q[p] <= ev.busy;
        end
      end
    end
  end

  always_comb begin
    zlp_d = 1'b0;
    for (int p = 0; p < NP; p++) begin
      if (ev_hit[p] && ev.out_empty && (ttep_q[p][5:4] == uhp_pkg::UHP_TOKEN_OUT) &&
          ((ttep_q[p][7:6] == uhp_pkg::UHP_TYPE_ISO) || (ttep_q[p][7:6] == uhp_pkg::UHP_TYPE_INTERRUPT))) begin
        zlp_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      zlp_send <= 1'b0;
    end else begin
      zlp_send <= zlp_d;
    end
  end

  // Flow flags clear only by a written zero; a new event in the same cycle wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_q <= 7'h00;
      underflow_q <= 7'h00;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit[p] && wr_stat) begin
          overflow_q[p] <= (overflow_q[p] && wd[`UHP_ST_OVF]) || (ev_hit[p] && ev.overflow);
          underflow_q[p] <= (underflow_q[p] && wd[`UHP_ST_UNF]) || (zlp_d && ev_hit[p]);
        end else begin
          overflow_q[p] <= overflow_q[p] || (ev_hit[p] && ev.overflow);
          underflow_q[p] <= underflow_q[p] || (zlp_d && ev_hit[p]);
        end
      end
    end
  end

  assign rp = (pipe_select_q < 3'(NP)) ? pipe_select_q : 3'h0;
  always_comb begin
    rd_byte = 8'h00;
    rd_bad = 1'b0;
    if (s_axi_araddr == `UHP_OFS_SELECT) begin
      rd_byte = {5'h00, pipe_select_q};
    end else if (s_axi_araddr == `UHP_OFS_CONTROL) begin
      rd_byte = {flow_en_q[rp], pipe_halt_q[rp], unbounded_q[rp], 1'b0, restart_q[rp], 2'h0, pipe_on_q[rp]};
    end else if (s_axi_araddr == `UHP_OFS_TTEP) begin
      rd_byte = ttep_q[rp];
    end else if (s_axi_araddr == `UHP_OFS_SIZE_BANKS) begin
      rd_byte = size_banks_q[rp];
    end else if (s_axi_araddr == `UHP_OFS_POLL) begin
      rd_byte = poll_q[rp];
    end else if (s_axi_araddr == `UHP_OFS_STATUS) begin
      rd_byte = {memory_allocate_ok_q[rp], overflow_q[rp], underflow_q[rp], 1'b0, 1'b0, toggle_q[rp], busy_q[rp]};
    end else if (s_axi_araddr == `UHP_OFS_INRQ) begin
      rd_byte = in_request_tally_q[rp];
    end else if (s_axi_araddr == `UHP_OFS_ERROR) begin
      rd_byte = {1'b0, error_tally[rp], err_flags[rp]};
    end else if (s_axi_araddr == `UHP_OFS_PIPE_RESET) begin
      rd_byte = {1'b0, pipe_reset_q};
    end else if (s_axi_araddr == `UHP_OFS_PIPE_FLAGS) begin
      rd_byte = {7'h00, |err_flags[rp]};
    end else begin
      rd_bad = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UHP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_bad ? `UHP_RESP_DECERR : `UHP_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_comb begin
    logic [2:0] ep;
    ep = (eng_pipe < 3'(NP)) ? eng_pipe : 3'h0;
    eng_view.transfer_type_sel = uhp_pkg::uhp_xfer_t'(ttep_q[ep][7:6]);
    eng_view.token_sel = uhp_pkg::uhp_token_t'(ttep_q[ep][5:4]);
    eng_view.target_endpoint = ttep_q[ep][3:0];
    eng_view.pipe_capacity_sel = size_banks_q[ep][`UHP_SB_SIZE_LSB +: 3];
    eng_view.bank_count_sel = size_banks_q[ep][`UHP_SB_BANK_LSB +: 2];
    eng_view.poll_period = (ttep_q[ep][7:6] == uhp_pkg::UHP_TYPE_INTERRUPT) ? poll_q[ep] : 8'h00;
    eng_view.toggle = toggle_q[ep];
    eng_view.req_ok = req_allowed[ep];
  end
endmodule
`default_nettype wire

//--- hdl/uhp_pkg.sv
`default_nettype none
package uhp_pkg;
  typedef enum logic [1:0] {
    UHP_TYPE_CONTROL = 2'h0,
    UHP_TYPE_ISO = 2'h1,
    UHP_TYPE_BULK = 2'h2,
    UHP_TYPE_INTERRUPT = 2'h3
  } uhp_xfer_t;

  typedef enum logic [1:0] {
    UHP_TOKEN_SETUP = 2'h0,
    UHP_TOKEN_IN = 2'h1,
    UHP_TOKEN_OUT = 2'h2,
    UHP_TOKEN_RSVD = 2'h3
  } uhp_token_t;

  typedef struct packed {
    logic valid;
    logic [2:0] pipe;
    logic in_ok;
    logic rx_toggle;
    logic tx_done;
    logic out_empty;
    logic overflow;
    logic stall;
    logic crc;
    logic timeout;
    logic pid;
    logic data_pid;
    logic toggle_bad;
    logic busy_upd;
    logic [1:0] busy;
  } uhp_event_t;

  typedef struct packed {
    uhp_xfer_t transfer_type_sel;
    uhp_token_t token_sel;
    logic [3:0] target_endpoint;
    logic [2:0] pipe_capacity_sel;
    logic [1:0] bank_count_sel;
    logic [7:0] poll_period;
    logic toggle;
    logic req_ok;
  } uhp_view_t;
endpackage
`default_nettype wire

//--- verif/testbench.sv
`include "uhp_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] eng_pipe = 3'h0;
  uhp_pkg::uhp_event_t ev;
  uhp_pkg::uhp_view_t eng_view;
  logic [6:0] req_allowed, flow_err_req;
  logic zlp_send;
  int num_errors = 0, cmp_count = 0, cyc = 0, zlp_cnt = 0;
  always #25 core_clk = ~core_clk;
  uhp_dev_model u_dev (.core_clk(core_clk), .ev(ev));
  uhp_pipe_ctl u_uhp_pipe_ctl (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ev(ev), .eng_pipe(eng_pipe), .eng_view(eng_view),
    .req_allowed(req_allowed), .flow_err_req(flow_err_req), .zlp_send(zlp_send)
  );
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (zlp_send === 1'b1) zlp_cnt++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Requests change only at an edge; each wait reads what the design showed as that edge arrived.
  // A fresh edge at the start keeps back-to-back calls from touching a valid twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(awready === 1'b1 && wready === 1'b1) && n < 100);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    chk({30'h0, bresp}, (a > `UHP_OFS_PIPE_FLAGS) ? 32'h3 : 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    chk(rdata, {24'h000000, x});
    chk({30'h0, rresp}, (a > `UHP_OFS_PIPE_FLAGS) ? 32'h3 : 32'h0);
  endtask
  function automatic uhp_pkg::uhp_event_t mk(input logic [2:0] p);
    uhp_pkg::uhp_event_t e;
    e = '0;
    e.valid = 1'b1;
    e.pipe = p;
    return e;
  endfunction
  logic [12:0] tbl [6] = '{13'h1156, 13'h0256, 13'h1232, 13'h023A, 13'h0230, 13'h0166};
  initial begin
    uhp_pkg::uhp_event_t e;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(`UHP_OFS_CONTROL, 8'h40);
    rd(`UHP_OFS_TTEP, 8'h00);
    rd(`UHP_OFS_STATUS, 8'h00);
    rd(8'h28, 8'h00);
    wr(8'h30, 8'h5A);
    $display("reset values done");
    wr(`UHP_OFS_POLL, 8'h5A);
    for (int t = 0; t < 4; t++) begin
      wr(`UHP_OFS_TTEP, {t[1:0], 2'(t % 3), 4'(t * 5)});
      rd(`UHP_OFS_TTEP, {t[1:0], 2'(t % 3), 4'(t * 5)});
      chk({30'h0, eng_view.transfer_type_sel}, 32'(t));
      chk({24'h0, eng_view.poll_period}, (t == 3) ? 32'h5A : 32'h0);
      chk({30'h0, eng_view.token_sel}, 32'(t % 3));
      chk({28'h0, eng_view.target_endpoint}, 32'(t * 5));
    end
    $display("field codes done");
    for (int i = 0; i < 6; i++) begin
      wr(`UHP_OFS_TTEP, {4'hA, tbl[i][11:8]});
      wr(`UHP_OFS_SIZE_BANKS, tbl[i][7:0]);
      rd(`UHP_OFS_SIZE_BANKS, tbl[i][7:0]);
      chk({29'h0, eng_view.pipe_capacity_sel}, {29'h0, tbl[i][6:4]});
      chk({30'h0, eng_view.bank_count_sel}, {30'h0, tbl[i][3:2]});
      wr(`UHP_OFS_CONTROL, 8'h01);
      rd(`UHP_OFS_STATUS, {tbl[i][12], 7'h00});
      wr(`UHP_OFS_CONTROL, 8'h00);
      rd(`UHP_OFS_STATUS, 8'h00);
    end
    $display("allocation done");
    wr(`UHP_OFS_SELECT, 8'h01);
    eng_pipe <= 3'h1;
    wr(`UHP_OFS_TTEP, 8'h91);
    wr(`UHP_OFS_SIZE_BANKS, 8'h02);
    wr(`UHP_OFS_CONTROL, 8'h01);
    rd(`UHP_OFS_CONTROL, 8'h41);
    wr(`UHP_OFS_CONTROL, 8'h01);
    wr(`UHP_OFS_INRQ, 8'h02);
    chk({25'h0, req_allowed}, 32'h02);
    for (int k = 0; k < 3; k++) begin
      e = mk(3'h1);
      e.in_ok = 1'b1;
      e.rx_toggle = k[0];
      u_dev.send(e, k);
      rd(`UHP_OFS_INRQ, (k < 2) ? 8'(1 - k) : 8'h00);
      rd(`UHP_OFS_STATUS, {5'h10, k[0], 2'h0});
      chk({31'h0, eng_view.toggle}, {31'h0, k[0]});
    end
    chk({25'h0, req_allowed}, 32'h00);
    rd(`UHP_OFS_CONTROL, 8'h41);
    $display("bounded requests done");
    wr(`UHP_OFS_CONTROL, 8'h21);
    wr(`UHP_OFS_INRQ, 8'h01);
    e = mk(3'h1);
    e.in_ok = 1'b1;
    e.rx_toggle = 1'b1;
    repeat (3) u_dev.send(e, 0);
    chk({25'h0, req_allowed}, 32'h02);
    chk({31'h0, eng_view.req_ok}, 32'h1);
    rd(`UHP_OFS_INRQ, 8'h01);
    rd(`UHP_OFS_STATUS, 8'h84);
    wr(`UHP_OFS_CONTROL, 8'h29);
    rd(`UHP_OFS_CONTROL, 8'h21);
    rd(`UHP_OFS_STATUS, 8'h80);
    $display("unbounded requests done");
    e = mk(3'h1);
    e.crc = 1'b1;
    u_dev.send(e, 0);
    rd(`UHP_OFS_ERROR, 8'h30);
    rd(`UHP_OFS_PIPE_FLAGS, 8'h01);
    wr(`UHP_OFS_ERROR, 8'h1F);
    rd(`UHP_OFS_ERROR, 8'h10);
    wr(`UHP_OFS_ERROR, 8'h00);
    rd(`UHP_OFS_PIPE_FLAGS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      e = mk(3'h1);
      {e.timeout, e.pid, e.data_pid, e.toggle_bad} = 4'h8 >> i;
      u_dev.send(e, 0);
    end
    rd(`UHP_OFS_ERROR, 8'h6F);
    chk({25'h0, req_allowed}, 32'h00);
    $display("error tracking done");
    wr(`UHP_OFS_SELECT, 8'h02);
    wr(`UHP_OFS_TTEP, 8'h62);
    wr(`UHP_OFS_SIZE_BANKS, 8'h02);
    wr(`UHP_OFS_CONTROL, 8'h81);
    e = mk(3'h2);
    e.out_empty = 1'b1;
    u_dev.send(e, 2);
    e = mk(3'h2);
    e.overflow = 1'b1;
    e.busy_upd = 1'b1;
    e.busy = 2'h2;
    u_dev.send(e, 0);
    rd(`UHP_OFS_STATUS, 8'hE2);
    chk(32'(zlp_cnt), 32'h1);
    chk({25'h0, flow_err_req}, 32'h04);
    wr(`UHP_OFS_STATUS, 8'hFF);
    rd(`UHP_OFS_STATUS, 8'hE2);
    wr(`UHP_OFS_STATUS, 8'h00);
    rd(`UHP_OFS_STATUS, 8'h82);
    chk({25'h0, flow_err_req}, 32'h00);
    rd(`UHP_OFS_ERROR, 8'h00);
    wr(`UHP_OFS_CONTROL, 8'h81);
    chk({25'h0, req_allowed}, 32'h04);
    wr(`UHP_OFS_PIPE_RESET, 8'h04);
    wr(`UHP_OFS_PIPE_RESET, 8'h00);
    rd(`UHP_OFS_CONTROL, 8'hC1);
    rd(`UHP_OFS_STATUS, 8'h80);
    e = mk(3'h2);
    e.tx_done = 1'b1;
    u_dev.send(e, 0);
    rd(`UHP_OFS_STATUS, 8'h84);
    $display("flow errors done");
    wr(`UHP_OFS_SELECT, 8'hFB);
    rd(`UHP_OFS_SELECT, 8'h03);
    wr(`UHP_OFS_CONTROL, 8'hFF);
    rd(`UHP_OFS_CONTROL, 8'hE1);
    $display("reserved bits done");
    final_report();
  end
endmodule
`default_nettype wire

//--- verif/uhp_checker.sv
`default_nettype none
module uhp_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire uhp_pkg::uhp_event_t ev,
  input wire uhp_pkg::uhp_view_t eng_view,
  input wire logic [6:0] req_allowed,
  input wire logic [6:0] flow_err_req,
  input wire logic zlp_send
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write taken without response");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_reset_halts: assert property ($fell(rst) |-> req_allowed == 7'h00)
    else $error("pipe active after reset");
  a_poll_masked: assert property (eng_view.transfer_type_sel != uhp_pkg::UHP_TYPE_INTERRUPT |->
    eng_view.poll_period == 8'h00) else $error("poll period shown for non-interrupt pipe");
  a_zlp_cause: assert property (zlp_send |-> $past(ev.valid && ev.out_empty))
    else $error("zero-length send without empty bank");
  a_flow_cause: assert property ((flow_err_req & ~$past(flow_err_req)) != 7'h00 |->
    $past(ev.valid && (ev.overflow || ev.out_empty)) || $past(s_axi_awvalid && s_axi_awready))
    else $error("flow error request without cause");
  a_req_cause: assert property ((req_allowed & ~$past(req_allowed)) != 7'h00 |->
    $past(s_axi_awvalid && s_axi_awready)) else $error("requests enabled without software write");
  c_zlp: cover property (zlp_send);
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
  c_req: cover property (req_allowed != 7'h00);
  c_flow: cover property (flow_err_req != 7'h00);
endmodule
bind uhp_pipe_ctl uhp_checker u_chk (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .ev(ev), .eng_view(eng_view), .req_allowed(req_allowed),
  .flow_err_req(flow_err_req), .zlp_send(zlp_send)
);
`default_nettype wire

//--- verif/uhp_dev_model.sv
`default_nettype none
module uhp_dev_model (
  input wire logic core_clk,
  output var uhp_pkg::uhp_event_t ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev = '0;
  // The payload is scrambled once the strobe drops, so a stale value is never mistaken for a new outcome.
  task automatic send(input uhp_pkg::uhp_event_t e, input int gap);
    uhp_pkg::uhp_event_t idle;
    idle = ~e;
    idle.valid = 1'b0;
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    ev <= e;
    @(posedge core_clk);
    ev <= idle;
  endtask
endmodule
`default_nettype wire
